// File: arsc_top.sv
// Shift datapath slice: register file, flags and AXI4-Lite access
//
// Summary of operation
// [RQ1] Register-count form shifts the target right by the low 5 bits of the count register.
// [RQ2] Vacated upper bits are filled with the original sign bit.
// [RQ3] Immediate form takes its 0..31 count from the zero-extended 5-bit immediate.
// [RQ4] A zero count leaves the target register exactly as it was.
// [RQ5] Register-count form writes only the target, never the count register.
// [RQ6] Carry takes the last bit shifted out of the low end.
// [RQ7] Carry is cleared for a zero count and wrap is always cleared by the shift.
// [RQ8] Negative follows bit 31 of the written result.
// [RQ9] Zero is set exactly when the whole result is zero.
// [RQ10] Conditional shift with a true condition shifts left by one and inserts a one.
// [RQ11] Conditional shift with a false condition shifts left by one and inserts a zero.
// [RQ12] A four-bit condition field selects one defined flag condition.
// [RQ13] The shift keeps the clamp flag; the conditional shift keeps all flags.
// [RQ14] The condition is judged on the flags as they stand at execution.
`timescale 1ns/1ps
`default_nettype none

module arsc_top #(
  parameter int DATA_W = 32,
  parameter int NUM_RF = 32
) (
  // Clock and reset
  input  wire logic                           core_clk,
  input  wire logic                           rst,
  // AXI4-Lite write address
  input  wire logic [arsc_pkg::ARSC_ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                           s_axi_awvalid,
  output logic                                s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0]                    s_axi_wdata,
  input  wire logic [3:0]                     s_axi_wstrb,
  input  wire logic                           s_axi_wvalid,
  output logic                                s_axi_wready,
  // AXI4-Lite write response
  output logic      [1:0]                     s_axi_bresp,
  output logic                                s_axi_bvalid,
  input  wire logic                           s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [arsc_pkg::ARSC_ADDR_W-1:0] s_axi_araddr,
  input  wire logic                           s_axi_arvalid,
  output logic                                s_axi_arready,
  // AXI4-Lite read data
  output logic      [31:0]                    s_axi_rdata,
  output logic      [1:0]                     s_axi_rresp,
  output logic                                s_axi_rvalid,
  input  wire logic                           s_axi_rready
);
  import arsc_pkg::*;

  // -----------------------------------------------------------------------
  // Storage
  // -----------------------------------------------------------------------
  logic        [DATA_W-1:0]      general_register_array [NUM_RF];
  arsc_flags_s                   flags;
  arsc_cmd_s                     exec_cmd;
  logic                          exec_pend;
  arsc_op_e                      last_op;
  logic                          last_met;
  logic        [15:0]            exec_count;

  // Write channel holding
  logic        [ARSC_ADDR_W-1:0] aw_addr;
  logic                          aw_held;
  logic        [31:0]            w_data;
  logic        [3:0]             w_strb;
  logic                          w_held;
  logic                          wr_do;
  logic        [31:0]            wr_mask;
  logic        [31:0]            wr_word;
  logic                          wr_hit_rf;
  logic                          wr_ok;

  // Read side
  logic        [31:0]            rd_word;
  logic                          rd_ok;
  logic                          rd_take;

  // Execution
  logic        [DATA_W-1:0]      tgt_value;
  logic        [DATA_W-1:0]      cnt_value;
  logic        [ARSC_CNT_W-1:0]  shift_count;
  logic        [DATA_W-1:0]      asr_result;
  logic                          asr_carry;
  logic                          asr_wrap;
  logic                          asr_neg;
  logic                          asr_zero;
  logic                          cond_met;
  logic        [DATA_W-1:0]      next_tgt;
  arsc_flags_s                   next_flags;
  logic                          exec_writes;

  // -----------------------------------------------------------------------
  // Write channel
  // -----------------------------------------------------------------------

  // Stall both channels while a response waits; each side taken alone
  assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_held & ~s_axi_bvalid;
  assign wr_do         = aw_held & w_held & ~s_axi_bvalid;

  // Address capture
  always_ff @(posedge core_clk) begin
    if (rst) begin
      aw_held <= 1'b0;
      aw_addr <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held <= 1'b1;
      aw_addr <= s_axi_awaddr;
    end else if (wr_do) begin
      aw_held <= 1'b0;
    end
  end

  // Data capture
  always_ff @(posedge core_clk) begin
    if (rst) begin
      w_held <= 1'b0;
      w_data <= '0;
      w_strb <= '0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held <= 1'b1;
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
    end else if (wr_do) begin
      w_held <= 1'b0;
    end
  end

  // Byte lanes expanded to a bit mask
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      wr_mask[i*8 +: 8] = {8{w_strb[i]}};
    end
  end

  // Command word takes unstrobed lanes as zero; the flag word is written only when lane 0 is strobed
  assign wr_word   = w_data & wr_mask;
  assign wr_hit_rf = aw_addr[ARSC_RF_SEL_BIT];

  // Address decode for writes
  always_comb begin
    wr_ok = wr_hit_rf;
    unique case (aw_addr)
      ARSC_CMD_OFFSET:    wr_ok = 1'b1;
      ARSC_FLAGS_OFFSET:  wr_ok = 1'b1;
      ARSC_STATUS_OFFSET: wr_ok = 1'b1;
      default:            ;
    endcase
  end

  // Response raised after both halves are in
  always_ff @(posedge core_clk) begin
    if (rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= ARSC_RESP_OKAY;
    end else if (wr_do) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_ok ? ARSC_RESP_OKAY : ARSC_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // -----------------------------------------------------------------------
  // Command launch
  // -----------------------------------------------------------------------

  // One cycle after the command write; bvalid blocks the next write
  always_ff @(posedge core_clk) begin
    if (rst) begin
      exec_pend <= 1'b0;
      exec_cmd  <= '0;
    end else begin
      exec_pend <= wr_do && (aw_addr == ARSC_CMD_OFFSET) &&
                   (arsc_op_e'(wr_word[1:0]) != ARSC_OP_IDLE);
      if (wr_do && (aw_addr == ARSC_CMD_OFFSET)) begin
        exec_cmd <= arsc_cmd_s'(wr_word);
      end
    end
  end

  // -----------------------------------------------------------------------
  // Operand fetch and datapath
  // -----------------------------------------------------------------------

  // Register zero always reads as zero
  assign tgt_value = (exec_cmd.tgt == '0) ? '0
                   : general_register_array[exec_cmd.tgt];
  assign cnt_value = (exec_cmd.src == '0) ? '0
                   : general_register_array[exec_cmd.src];

  // [RQ1] low five count bits
  // [RQ3] immediate zero-extended
  always_comb begin
    if (exec_cmd.op == ARSC_OP_ARITH_REG) begin
      shift_count = cnt_value[ARSC_CNT_W-1:0];
    end else begin
      shift_count = exec_cmd.src;
    end
  end

  arsc_shifter #(
    .DATA_W (DATA_W),
    .CNT_W  (ARSC_CNT_W)
  ) u_shifter (
    .operand      (tgt_value),
    .count        (shift_count),
    .result       (asr_result),
    .carry_out    (asr_carry),
    .wrap_out     (asr_wrap),
    .negative_out (asr_neg),
    .zero_out     (asr_zero)
  );

  // [RQ14] flags as they stand now
  arsc_cond_eval u_cond (
    .cond  (exec_cmd.cond),
    .flags (flags),
    .met   (cond_met)
  );

  // Result and flag selection per operation
  always_comb begin
    next_tgt    = tgt_value;
    next_flags  = flags;
    exec_writes = 1'b0;
    unique case (exec_cmd.op)
      ARSC_OP_ARITH_REG,
      ARSC_OP_ARITH_IMM: begin
        // [RQ4] zero count keeps value
        next_tgt    = (shift_count == '0) ? tgt_value : asr_result;
        exec_writes = 1'b1;
        // [RQ13] clamp flag kept
        next_flags.carry_flag        = asr_carry;
        next_flags.signed_wrap_flag  = asr_wrap;
        next_flags.negative_flag     = asr_neg;
        next_flags.zero_flag         = asr_zero;
      end
      ARSC_OP_COND_SHIFT: begin
        // [RQ10] true inserts one
        // [RQ11] false inserts zero
        next_tgt    = {tgt_value[DATA_W-2:0], cond_met};
        exec_writes = 1'b1;
      end
      ARSC_OP_IDLE: begin
        exec_writes = 1'b0;
      end
    endcase
  end

  // -----------------------------------------------------------------------
  // General register array
  // -----------------------------------------------------------------------

  // [RQ5] only target written
  // Bus writes and execution never share a cycle, so no arbitration
  always_ff @(posedge core_clk) begin
    if (rst) begin
      for (int i = 0; i < NUM_RF; i++) begin
        general_register_array[i] <= ARSC_RF_RESET;
      end
    end else if (exec_pend && exec_writes) begin
      general_register_array[exec_cmd.tgt] <= next_tgt;
    end else if (wr_do && wr_hit_rf) begin
      general_register_array[aw_addr[ARSC_RF_SEL_BIT-1:2]] <=
        (general_register_array[aw_addr[ARSC_RF_SEL_BIT-1:2]] & ~wr_mask)
        | wr_word;
    end
  end

  // -----------------------------------------------------------------------
  // Program status flags
  // -----------------------------------------------------------------------

  // Software may preset flags to steer the conditional shift
  always_ff @(posedge core_clk) begin
    if (rst) begin
      flags <= arsc_flags_s'(ARSC_FLAGS_RESET);
    end else if (exec_pend) begin
      flags <= next_flags;
    end else if (wr_do && (aw_addr == ARSC_FLAGS_OFFSET) && w_strb[0]) begin
      flags <= arsc_flags_s'(w_data[4:0]);
    end
  end

  // -----------------------------------------------------------------------
  // Execution status
  // -----------------------------------------------------------------------

  // Last operation, its verdict and a wrapping execution count
  always_ff @(posedge core_clk) begin
    if (rst) begin
      last_op    <= ARSC_OP_IDLE;
      last_met   <= 1'b0;
      exec_count <= ARSC_COUNT_RESET;
    end else if (exec_pend) begin
      last_op    <= exec_cmd.op;
      last_met   <= (exec_cmd.op == ARSC_OP_COND_SHIFT) & cond_met;
      exec_count <= exec_count + 16'h0001;
    end
  end

  // -----------------------------------------------------------------------
  // Read channel
  // -----------------------------------------------------------------------

  assign s_axi_arready = ~s_axi_rvalid;
  assign rd_take       = s_axi_arvalid & s_axi_arready;

  // Read decode; status reserved bits and unmapped words read as zero
  always_comb begin
    rd_word = '0;
    rd_ok   = 1'b1;
    if (s_axi_araddr[ARSC_RF_SEL_BIT]) begin
      if (s_axi_araddr[ARSC_RF_SEL_BIT-1:2] != '0) begin
        rd_word = general_register_array[s_axi_araddr[ARSC_RF_SEL_BIT-1:2]];
      end
    end else begin
      unique case (s_axi_araddr)
        ARSC_CMD_OFFSET:    rd_word = 32'(exec_cmd);
        ARSC_FLAGS_OFFSET:  rd_word = {27'h0000000, flags};
        ARSC_STATUS_OFFSET: begin
          rd_word[ARSC_STAT_MET_BIT]        = last_met;
          rd_word[ARSC_STAT_OP_LSB +: 2]    = last_op;
          rd_word[ARSC_STAT_CNT_LSB +: 16]  = exec_count;
        end
        default:            rd_ok = 1'b0;
      endcase
    end
  end

  // Read data registered; held until rready
  always_ff @(posedge core_clk) begin
    if (rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= ARSC_RESP_OKAY;
    end else if (rd_take) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_word;
      s_axi_rresp  <= rd_ok ? ARSC_RESP_OKAY : ARSC_RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule

`default_nettype wire

// File: arsc_pkg.sv
// Package: constants, register map and carrier types of the shift datapath
package arsc_pkg;

  // ---------------------------------------------------------------------
  // Widths
  // ---------------------------------------------------------------------
  localparam int ARSC_DATA_W  = 32;
  localparam int ARSC_ADDR_W  = 8;
  localparam int ARSC_CNT_W   = 5;
  localparam int ARSC_IDX_W   = 5;
  localparam int ARSC_NUM_RF  = 32;

  // ---------------------------------------------------------------------
  // Register map (byte addresses)
  // ---------------------------------------------------------------------
  localparam logic [7:0] ARSC_CMD_OFFSET    = 8'h00;
  localparam logic [7:0] ARSC_FLAGS_OFFSET  = 8'h04;
  localparam logic [7:0] ARSC_STATUS_OFFSET = 8'h08;
  localparam logic [7:0] ARSC_RF_BASE       = 8'h80;
  localparam int         ARSC_RF_SEL_BIT    = 7;

  // ---------------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------------
  localparam logic [31:0] ARSC_RF_RESET     = 32'h0000_0000;
  localparam logic [4:0]  ARSC_FLAGS_RESET  = 5'h00;
  localparam logic [15:0] ARSC_COUNT_RESET  = 16'h0000;

  // ---------------------------------------------------------------------
  // AXI4-Lite responses
  // ---------------------------------------------------------------------
  localparam logic [1:0] ARSC_RESP_OKAY   = 2'h0;
  localparam logic [1:0] ARSC_RESP_SLVERR = 2'h2;

  // ---------------------------------------------------------------------
  // Operations launched through the command register
  // ---------------------------------------------------------------------
  typedef enum logic [1:0] {
    ARSC_OP_IDLE,
    ARSC_OP_ARITH_REG,
    ARSC_OP_ARITH_IMM,
    ARSC_OP_COND_SHIFT
  } arsc_op_e;

  // Command word layout: op [1:0], target [8:4], source [16:12],
  // condition [23:20]; other bits ignored
  typedef struct packed {
    logic [7:0]             unused_hi;
    logic [3:0]             cond;
    logic [2:0]             pad2;
    logic [ARSC_IDX_W-1:0]  src;
    logic [2:0]             pad1;
    logic [ARSC_IDX_W-1:0]  tgt;
    logic [1:0]             pad0;
    arsc_op_e               op;
  } arsc_cmd_s;

  // Program status flags, bit 0 upward: zero, negative, wrap, carry, clamp
  typedef struct packed {
    logic clamp_sticky_flag;
    logic carry_flag;
    logic signed_wrap_flag;
    logic negative_flag;
    logic zero_flag;
  } arsc_flags_s;

  // Status word: exec count [31:16], last op [5:4], condition met [0]
  localparam int ARSC_STAT_MET_BIT  = 0;
  localparam int ARSC_STAT_OP_LSB   = 4;
  localparam int ARSC_STAT_CNT_LSB  = 16;

  // ---------------------------------------------------------------------
  // Condition codes
  // ---------------------------------------------------------------------
  localparam logic [3:0] ARSC_COND_WRAP       = 4'h0;
  localparam logic [3:0] ARSC_COND_CARRY      = 4'h1;
  localparam logic [3:0] ARSC_COND_ZERO       = 4'h2;
  localparam logic [3:0] ARSC_COND_NOT_HIGHER = 4'h3;
  localparam logic [3:0] ARSC_COND_NEG        = 4'h4;
  localparam logic [3:0] ARSC_COND_ALWAYS     = 4'h5;
  localparam logic [3:0] ARSC_COND_LESS       = 4'h6;
  localparam logic [3:0] ARSC_COND_LESS_EQ    = 4'h7;
  localparam logic [3:0] ARSC_COND_NO_WRAP    = 4'h8;
  localparam logic [3:0] ARSC_COND_NO_CARRY   = 4'h9;
  localparam logic [3:0] ARSC_COND_NONZERO    = 4'hA;
  localparam logic [3:0] ARSC_COND_HIGHER     = 4'hB;
  localparam logic [3:0] ARSC_COND_POS        = 4'hC;
  localparam logic [3:0] ARSC_COND_CLAMPED    = 4'hD;
  localparam logic [3:0] ARSC_COND_GREATER_EQ = 4'hE;
  localparam logic [3:0] ARSC_COND_GREATER    = 4'hF;

endpackage

// File: arsc_shifter.sv
// Arithmetic right shifter with carry, wrap, negative and zero results
`timescale 1ns/1ps
`default_nettype none

module arsc_shifter #(
  parameter int DATA_W = 32,
  parameter int CNT_W  = 5
) (
  // Operand and count
  input  wire logic [DATA_W-1:0] operand,
  input  wire logic [CNT_W-1:0]  count,
  // Result and flags
  output logic      [DATA_W-1:0] result,
  output logic                   carry_out,
  output logic                   wrap_out,
  output logic                   negative_out,
  output logic                   zero_out
);

  logic [DATA_W-1:0] last_out;

  // [RQ2] sign bit copied in
  // Signed shift fills vacated upper bits with the old MSB
  always_comb begin
    result = $signed(operand) >>> count;
  end

  // [RQ6] last bit out
  // Bit n-1 is the last to leave the low end; count 0 gives no carry
  always_comb begin
    last_out  = operand >> (count - CNT_W'(1));
    // [RQ7] carry and wrap cleared
    carry_out = (count == '0) ? 1'b0 : last_out[0];
    wrap_out  = 1'b0;
  end

  // [RQ8] negative from bit 31
  assign negative_out = result[DATA_W-1];
  // [RQ9] zero on all-zero result
  assign zero_out     = (result == '0);

endmodule

`default_nettype wire

// File: arsc_cond_eval.sv
// Condition evaluator over the program status flags
`timescale 1ns/1ps
`default_nettype none

module arsc_cond_eval (
  // Selector and flags
  input  wire logic                 [3:0] cond,
  input  wire arsc_pkg::arsc_flags_s      flags,
  // Verdict
  output logic                            met
);
  import arsc_pkg::*;

  logic c;
  logic v;
  logic s;
  logic z;
  logic cl;

  assign c   = flags.carry_flag;
  assign v   = flags.signed_wrap_flag;
  assign s   = flags.negative_flag;
  assign z   = flags.zero_flag;
  assign cl  = flags.clamp_sticky_flag;

  // [RQ12] four-bit selector
  // All sixteen codes are defined, so no illegal entry exists
  always_comb begin
    unique case (cond)
      ARSC_COND_WRAP:       met = v;
      ARSC_COND_CARRY:      met = c;
      ARSC_COND_ZERO:       met = z;
      ARSC_COND_NOT_HIGHER: met = c | z;
      ARSC_COND_NEG:        met = s;
      ARSC_COND_ALWAYS:     met = 1'b1;
      ARSC_COND_LESS:       met = s ^ v;
      ARSC_COND_LESS_EQ:    met = (s ^ v) | z;
      ARSC_COND_NO_WRAP:    met = ~v;
      ARSC_COND_NO_CARRY:   met = ~c;
      ARSC_COND_NONZERO:    met = ~z;
      ARSC_COND_HIGHER:     met = ~(c | z);
      ARSC_COND_POS:        met = ~s;
      ARSC_COND_CLAMPED:    met = cl;
      ARSC_COND_GREATER_EQ: met = ~(s ^ v);
      ARSC_COND_GREATER:    met = ~((s ^ v) | z);
    endcase
  end

endmodule

`default_nettype wire

// File: arsc_top_assertions.sv
// Register-port handshake assertions for the shift datapath
`timescale 1ns/1ps
`default_nettype none

module arsc_top_assertions (
  // Clock and reset
  input wire logic        core_clk,
  input wire logic        rst,
  // Write side
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  // Read side
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready
);
  // ---------------------------------------------------------
  // Handshake sequences
  // ---------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  sequence wr_both;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence

  // ---------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------
  // Answers come a fixed number of edges after the request
  write_answer_a: assert property (wr_both |=> !s_axi_bvalid ##1 s_axi_bvalid)
    else $error("write response timing wrong");
  read_answer_a: assert property (rd_take |=> s_axi_rvalid)
    else $error("read data late");
  // Answers stand until taken; a taken read drops at once
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable({s_axi_rresp, s_axi_rdata}))
    else $error("read data dropped");
  read_release_a: assert property (s_axi_rvalid && s_axi_rready |=>
    !s_axi_rvalid) else $error("rvalid stuck");
  // One transfer in flight per direction
  write_block_a: assert property (s_axi_bvalid |->
    !s_axi_awready && !s_axi_wready) else $error("write accepted early");
  read_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted early");
  reset_idle_a: assert property ($fell(rst) |-> s_axi_awready &&
    s_axi_wready && s_axi_arready && !s_axi_bvalid && !s_axi_rvalid)
    else $error("port not idle after reset");
endmodule

bind arsc_top arsc_top_assertions chk (.core_clk, .rst, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
  .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
  .s_axi_rvalid, .s_axi_rready);
`default_nettype wire

// File: tb_arith_right_shift_and_cond_shift.sv
// Self-checking bench for the shift datapath slice
`timescale 1ns/1ps
`default_nettype none

module tb_arith_right_shift_and_cond_shift;
  import arsc_pkg::*;
  // ---------------------------------------------------------
  // Signals and reference state
  // ---------------------------------------------------------
  logic        core_clk, rst, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic        s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
  logic        s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, seed, v;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [1:0]  exp_b [$];
  logic [33:0] exp_r [$];
  logic [33:0] want;
  logic [31:0] rf [32];
  logic [4:0]  cnt_tab [8] = '{0, 1, 31, 30, 16, 7, 0, 1};
  arsc_flags_s flg;
  int          error_cnt, n_checks, i;

  arsc_top dut (.core_clk, .rst, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

  // Clock generator
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  // ---------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  function automatic logic met(input logic [3:0] c, input arsc_flags_s f);
    logic sv;
    logic b;
    sv = f.negative_flag ^ f.signed_wrap_flag;
    case (c[2:0])
      3'h0: b = f.signed_wrap_flag;
      3'h1: b = f.carry_flag;
      3'h2: b = f.zero_flag;
      3'h3: b = f.carry_flag | f.zero_flag;
      3'h4: b = f.negative_flag;
      3'h6: b = sv;
      default: b = sv | f.zero_flag;
    endcase
    if (c == 4'h5) return 1'b1;
    if (c == 4'hD) return f.clamp_sticky_flag;
    return c[3] ? !b : b;
  endfunction

  function automatic logic [7:0] ga(input int r);
    return ARSC_RF_BASE + 8'(4 * r);
  endfunction

  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Bounded wait: a stuck handshake ends the run
  task automatic step(inout int k);
    @(posedge core_clk);
    k++;
    if (k > 200) begin
      error_cnt++;
      $display("mismatch at %0t: handshake timeout", $time);
      results();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] r);
    int   k;
    logic aw_p;
    logic w_p;
    logic b_p;
    k = 0;
    aw_p = 1'b1;
    w_p = 1'b1;
    b_p = 1'b1;
    exp_b.push_back(r);
    @(posedge core_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (aw_p || w_p || b_p) begin
      step(k);
      if (b_p && s_axi_bvalid) begin
        b_p = !s_axi_bready;
        s_axi_bready <= !s_axi_bready;
      end
      if (aw_p && s_axi_awready) begin
        aw_p = 1'b0;
        s_axi_awvalid <= 1'b0;
      end
      if (w_p && s_axi_wready) begin
        w_p = 1'b0;
        s_axi_wvalid <= 1'b0;
      end
    end
  endtask

  task automatic rd(input logic [7:0] a, input logic [33:0] e);
    int   k;
    logic ar_p;
    logic r_p;
    k = 0;
    ar_p = 1'b1;
    r_p = 1'b1;
    exp_r.push_back(e);
    @(posedge core_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    while (ar_p || r_p) begin
      step(k);
      if (r_p && s_axi_rvalid) begin
        r_p = !s_axi_rready;
        s_axi_rready <= !s_axi_rready;
      end
      if (ar_p && s_axi_arready) begin
        ar_p = 1'b0;
        s_axi_arvalid <= 1'b0;
      end
    end
  endtask

  task automatic set_rf(input int r, input logic [31:0] d);
    wr(ga(r), d, ARSC_RESP_OKAY);
    rf[r] = d;
  endtask

  task automatic chk(input int r);
    rd(ga(r), {ARSC_RESP_OKAY, rf[r]});
    rd(ARSC_FLAGS_OFFSET, {ARSC_RESP_OKAY, 27'h0, flg});
  endtask

  // Launch a command and advance the reference model
  task automatic run(input arsc_op_e op, input int t, input int s,
                     input logic [3:0] cc);
    arsc_cmd_s  c;
    logic [4:0] n;
    c = '0;
    c.op = op;
    c.tgt = 5'(t);
    c.src = 5'(s);
    c.cond = cc;
    wr(ARSC_CMD_OFFSET, c, ARSC_RESP_OKAY);
    v = rf[t];
    if (op == ARSC_OP_COND_SHIFT) begin
      rf[t] = {v[30:0], met(cc, flg)};
    end else begin
      n = (op == ARSC_OP_ARITH_REG) ? rf[s][4:0] : 5'(s);
      rf[t] = $signed(v) >>> n;
      flg.carry_flag = (n == 5'h0) ? 1'b0 : v[n - 5'h1];
      flg.signed_wrap_flag = 1'b0;
      flg.negative_flag = rf[t][31];
      flg.zero_flag = (rf[t] == 32'h0);
    end
  endtask

  // Scoreboard: oldest note against each response
  always @(posedge core_clk) begin
    if (s_axi_bvalid && s_axi_bready) begin
      n_checks++;
      if (s_axi_bresp !== exp_b.pop_front()) begin
        error_cnt++;
        $display("mismatch at %0t: bresp %h", $time, s_axi_bresp);
      end
    end
    if (s_axi_rvalid && s_axi_rready) begin
      n_checks++;
      want = exp_r.pop_front();
      if ({s_axi_rresp, s_axi_rdata} !== want) begin
        error_cnt++;
        $display("mismatch at %0t: read %h want %h", $time,
                 {s_axi_rresp, s_axi_rdata}, want);
      end
    end
  end

  // ---------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------
  initial begin
    rst = 1'b1;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = 18'h0;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hF;
    seed = 32'h0000_0041;
    error_cnt = 0;
    n_checks = 0;
    flg = '0;
    rf = '{default: 32'h0};
    repeat (16) @(posedge core_clk);
    rst <= 1'b0;
    chk(7);
    $display("test reset done");
    // Clamp and wrap preset: shift must keep one, clear the other
    wr(ARSC_FLAGS_OFFSET, 32'h0000_001F, ARSC_RESP_OKAY);
    flg = 5'h1F;
    for (i = 0; i < 8; i++) begin
      seed = lfsr(seed);
      set_rf(3, (i == 7) ? 32'h0000_0001 : seed);
      seed = lfsr(seed);
      set_rf(9, {seed[31:5], cnt_tab[i]});
      run(ARSC_OP_ARITH_REG, 3, 9, 4'h0);
      chk(3);
      rd(ga(9), {ARSC_RESP_OKAY, rf[9]});
    end
    $display("test register count done");
    for (i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      set_rf(4, seed);
      run(ARSC_OP_ARITH_IMM, 4, cnt_tab[i], 4'h0);
      chk(4);
    end
    $display("test immediate done");
    for (i = 0; i < 32; i++) begin
      seed = lfsr(seed);
      wr(ARSC_FLAGS_OFFSET, {27'h0, seed[4:0]}, ARSC_RESP_OKAY);
      flg = seed[4:0];
      set_rf(5, seed);
      run(ARSC_OP_COND_SHIFT, 5, 0, 4'(i));
      chk(5);
    end
    rd(ARSC_STATUS_OFFSET, {ARSC_RESP_OKAY, 16'h002C, 10'h000,
       2'h3, 3'h0, met(4'hF, flg)});
    $display("test conditional shift done");
    // Unmapped address is refused with no data
    wr(8'h40, seed, ARSC_RESP_SLVERR);
    rd(8'h40, {ARSC_RESP_SLVERR, 32'h0});
    $display("test unmapped done");
    results();
  end
endmodule
`default_nettype wire
